// file: verilog/ssi_pkg.sv
// Constants, field layouts and carrier types of the serial master FIFO block.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
//
// Notes on behaviour
// - Each data port read of a non-empty receive FIFO pops one entry; only the shifter fills that FIFO.
// - Receive-full interrupt holds while receive level is at least threshold plus one.
// - Receive-full interrupt drops by itself once reads lower the level.
// - Transmit-empty interrupt holds while transmit level is at most the threshold.
// - Frame arriving at a full receive FIFO is dropped and sets sticky overflow.
// - Reading an empty receive FIFO returns zero and sets sticky underflow.
// - Writing a full transmit FIFO is dropped and sets sticky overflow.
// - Being selected by another master while enabled sets a sticky contention flag.
// - Each source is maskable; one combined request is the OR of masked sources.
// - All interrupt outputs are active-high levels held while their cause holds.
// - Frame size comes from control zero bits 20:16; bits 3:0 are ignored.
// - Both FIFOs and the data port carry all 32 bits.
// - Mode 00 sends popped frames and stores every received frame.
// - Transmit-only mode never stores received frames.
// - Receive-only mode holds the output line constant and stores every frame.
// - EEPROM read sends until transmit FIFO empties, then stores read frames.
// - EEPROM read mode exists only in master configuration.
// - Mode field ignored for three-wire format, which uses its own control register.
// - Each FIFO holds 16 right-justified frames.
// - Both FIFOs empty whenever the block is disabled or reset.
// - Receive-only and EEPROM read end after frame count field plus one frames.

package ssi_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL0      = 8'h00;
   localparam logic [7:0] OFF_CTRL1      = 8'h04;
   localparam logic [7:0] OFF_ENABLE     = 8'h08;
   localparam logic [7:0] OFF_BAUD       = 8'h14;
   localparam logic [7:0] OFF_THREE_WIRE = 8'h0c;
   localparam logic [7:0] OFF_TX_THRESH  = 8'h18;
   localparam logic [7:0] OFF_RX_THRESH  = 8'h1c;
   localparam logic [7:0] OFF_TX_LEVEL   = 8'h20;
   localparam logic [7:0] OFF_RX_LEVEL   = 8'h24;
   localparam logic [7:0] OFF_STATUS     = 8'h28;
   localparam logic [7:0] OFF_MASK       = 8'h2c;
   localparam logic [7:0] OFF_IRQ_STAT   = 8'h30;
   localparam logic [7:0] OFF_IRQ_RAW    = 8'h34;
   localparam logic [7:0] OFF_TXO_CLR    = 8'h38;
   localparam logic [7:0] OFF_RXO_CLR    = 8'h3c;
   localparam logic [7:0] OFF_RXU_CLR    = 8'h40;
   localparam logic [7:0] OFF_MST_CLR    = 8'h44;
   localparam logic [7:0] OFF_DATA       = 8'h60;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL0_DFS_LSB  = 16;
   localparam int CTRL0_TRANSFER_MODE_FIELD_LSB = 8;
   localparam int CTRL0_FRF_LSB  = 4;

   // ----------------------------------------
   // Encodings and reset values
   // ----------------------------------------
   localparam logic [1:0] MODE_TXRX   = 2'h0;
   localparam logic [1:0] MODE_TX     = 2'h1;
   localparam logic [1:0] MODE_RX     = 2'h2;
   localparam logic [1:0] MODE_EEPROM = 2'h3;
   localparam logic [1:0] FRF_THREE_WIRE = 2'h2;
   localparam logic       MOSI_IDLE  = 1'h0;
   localparam int         FIFO_DEPTH = 16;
   localparam int         DATA_W     = 32;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } spi_out_t;

   typedef struct packed {
      logic ss_in_n;
      logic miso;
   } spi_in_t;

   typedef struct packed {
      logic mst;
      logic rxf;
      logic rxo;
      logic rxu;
      logic txo;
      logic txe;
   } irq_t;

   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} xfer_state_t;

endpackage

// file: verilog/ssi_fifo_ctrl.sv
// Serial master with transmit and receive FIFOs, threshold interrupts and
// four transfer modes, reached over AHB-Lite.
// Assumes miso and ss_in_n arrive asynchronously and hclk is the only clock.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.

`timescale 1ns/10ps
`default_nettype none

module ssi_fifo_ctrl #(
   parameter int DEPTH = ssi_pkg::FIFO_DEPTH
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire ssi_pkg::spi_in_t  spi_in,
   output ssi_pkg::spi_out_t      spi_out,
   output ssi_pkg::irq_t          irq,
   output logic                   irq_combined
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][31:0] tx_mem;
      logic [DEPTH-1:0][31:0] rx_mem;
      logic [AW-1:0]          tx_rd;
      logic [AW-1:0]          tx_wr;
      logic [AW-1:0]          rx_rd;
      logic [AW-1:0]          rx_wr;
      logic [AW:0]            tx_cnt;
      logic [AW:0]            rx_cnt;
      logic [4:0]             dfs;
      logic [1:0]             transfer_mode_field;
      logic [1:0]             frf;
      logic [15:0]            frame_count_minus_one;
      logic                   en;
      logic [15:0]            baud;
      logic                   mw_dir;
      logic [AW-1:0]          txft;
      logic [AW-1:0]          rxft;
      logic [5:0]             mask;
      logic                   txo;
      logic                   rxo;
      logic                   rxu;
      logic                   mst;
      logic                   dp_valid;
      logic [7:0]             dp_addr;
      logic [31:0]            rdata;
      ssi_pkg::xfer_state_t   st;
      logic [15:0]            div;
      logic [5:0]             bits;
      logic [15:0]            frames;
      logic                   rx_phase;
      logic [31:0]            tx_sr;
      logic [31:0]            rx_sr;
      logic                   sclk;
      logic                   cs_act;
      logic                   mosi;
      logic [2:0]             sel_sync;
      logic [2:0]             miso_sync;
      logic                   sel_filt;
      logic                   miso_filt;
   } state_t;

   state_t             q;
   state_t             d;
   ssi_pkg::irq_t      raw;
   logic [1:0]         mode;
   logic [15:0]        half;
   logic               tick;
   logic               acc;
   logic               tx_push;
   logic               tx_pop;
   logic               rx_push;
   logic               rx_pop;
   logic [31:0]        rx_word;
   logic [31:0]        pop_word;
   logic [31:0]        rd_val;
   logic [31:0]        shifted;

   // ----------------------------------------
   // Interrupt sources
   // ----------------------------------------
   always_comb
   begin
      raw.txe = q.tx_cnt <= {1'b0, q.txft};
      raw.rxf = q.rx_cnt >= ({1'b0, q.rxft} + (AW + 1)'(1));
      raw.txo = q.txo;
      raw.rxo = q.rxo;
      raw.rxu = q.rxu;
      raw.mst = q.mst;
   end

   assign irq          = raw & q.mask;
   assign irq_combined = |(raw & q.mask);
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = q.rdata;
   assign spi_out.sclk = q.sclk;
   assign spi_out.cs_n = ~q.cs_act;
   assign spi_out.mosi = q.mosi;

   // Three-wire format ignores the mode field and follows its own direction bit
   assign mode = (q.frf == ssi_pkg::FRF_THREE_WIRE) ?
                 (q.mw_dir ? ssi_pkg::MODE_TX : ssi_pkg::MODE_TXRX) : q.transfer_mode_field;
   // Divisor is the full sclk period; zero stops the serial clock
   assign half = {1'b0, q.baud[15:1]};
   assign tick = (half != 16'h0000) && ((q.div + 16'h0001) >= half);
   assign acc  = hsel && htrans[1] && hready;
   assign pop_word = q.tx_mem[q.tx_rd];
   // Received bits are right-justified; stale upper bits are cleared
   assign rx_word = q.rx_sr & (32'hffffffff >> (5'd31 - q.dfs));
   assign shifted = q.tx_sr << 1;

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always_comb
   begin
      rd_val = 32'h0;
      unique case (haddr[7:0])
         ssi_pkg::OFF_CTRL0:
         begin
            rd_val[ssi_pkg::CTRL0_DFS_LSB +: 5]  = q.dfs;
            rd_val[ssi_pkg::CTRL0_TRANSFER_MODE_FIELD_LSB +: 2] = q.transfer_mode_field;
            rd_val[ssi_pkg::CTRL0_FRF_LSB +: 2]  = q.frf;
         end
         ssi_pkg::OFF_CTRL1:      rd_val[15:0]   = q.frame_count_minus_one;
         ssi_pkg::OFF_ENABLE:     rd_val[0]      = q.en;
         ssi_pkg::OFF_BAUD:       rd_val[15:0]   = q.baud;
         ssi_pkg::OFF_THREE_WIRE: rd_val[0]      = q.mw_dir;
         ssi_pkg::OFF_TX_THRESH:  rd_val[AW-1:0] = q.txft;
         ssi_pkg::OFF_RX_THRESH:  rd_val[AW-1:0] = q.rxft;
         ssi_pkg::OFF_TX_LEVEL:   rd_val[AW:0]   = q.tx_cnt;
         ssi_pkg::OFF_RX_LEVEL:   rd_val[AW:0]   = q.rx_cnt;
         ssi_pkg::OFF_STATUS:
         begin
            rd_val[0] = q.st != ssi_pkg::ST_IDLE;
            rd_val[1] = q.tx_cnt != FULL;
            rd_val[2] = q.tx_cnt == '0;
            rd_val[3] = q.rx_cnt != '0;
            rd_val[4] = q.rx_cnt == FULL;
         end
         ssi_pkg::OFF_MASK:       rd_val[5:0] = q.mask;
         ssi_pkg::OFF_IRQ_STAT:   rd_val[5:0] = raw & q.mask;
         ssi_pkg::OFF_IRQ_RAW:    rd_val[5:0] = raw;
         ssi_pkg::OFF_TXO_CLR:    rd_val[0]   = q.txo;
         ssi_pkg::OFF_RXO_CLR:    rd_val[0]   = q.rxo;
         ssi_pkg::OFF_RXU_CLR:    rd_val[0]   = q.rxu;
         ssi_pkg::OFF_MST_CLR:    rd_val[0]   = q.mst;
         ssi_pkg::OFF_DATA:       rd_val      = (q.rx_cnt != '0) ? q.rx_mem[q.rx_rd] : 32'h0;
         default:                 rd_val      = 32'h0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      d       = q;
      tx_push = 1'b0;
      tx_pop  = 1'b0;
      rx_push = 1'b0;
      rx_pop  = 1'b0;

      // Pins pass three flops; a level counts once the last two agree
      d.sel_sync  = {q.sel_sync[1:0], ~spi_in.ss_in_n};
      d.miso_sync = {q.miso_sync[1:0], spi_in.miso};
      if (q.sel_sync[1] == q.sel_sync[2])
         d.sel_filt = q.sel_sync[2];
      if (q.miso_sync[1] == q.miso_sync[2])
         d.miso_filt = q.miso_sync[2];

      // Address phase: reads answer next cycle and take their side effects now
      d.dp_valid = acc && hwrite;
      d.dp_addr  = haddr[7:0];
      if (acc && !hwrite)
      begin
         d.rdata = rd_val;
         unique case (haddr[7:0])
            ssi_pkg::OFF_DATA:
            begin
               if (q.rx_cnt != '0)
                  rx_pop = 1'b1;
               else
                  d.rxu = 1'b1;
            end
            ssi_pkg::OFF_TXO_CLR: d.txo = 1'b0;
            ssi_pkg::OFF_RXO_CLR: d.rxo = 1'b0;
            ssi_pkg::OFF_RXU_CLR: d.rxu = 1'b0;
            ssi_pkg::OFF_MST_CLR: d.mst = 1'b0;
            default: d.rdata = rd_val;
         endcase
      end

      // Data phase of a write
      if (q.dp_valid)
      begin
         unique case (q.dp_addr)
            ssi_pkg::OFF_CTRL0:
            begin
               // Legacy size bits 3:0 are not stored
               d.dfs  = hwdata[ssi_pkg::CTRL0_DFS_LSB +: 5];
               d.transfer_mode_field = hwdata[ssi_pkg::CTRL0_TRANSFER_MODE_FIELD_LSB +: 2];
               d.frf  = hwdata[ssi_pkg::CTRL0_FRF_LSB +: 2];
            end
            ssi_pkg::OFF_CTRL1:      d.frame_count_minus_one    = hwdata[15:0];
            ssi_pkg::OFF_ENABLE:     d.en     = hwdata[0];
            ssi_pkg::OFF_BAUD:       d.baud   = hwdata[15:0];
            ssi_pkg::OFF_THREE_WIRE: d.mw_dir = hwdata[0];
            ssi_pkg::OFF_TX_THRESH:  d.txft   = hwdata[AW-1:0];
            ssi_pkg::OFF_RX_THRESH:  d.rxft   = hwdata[AW-1:0];
            ssi_pkg::OFF_MASK:       d.mask   = hwdata[5:0];
            ssi_pkg::OFF_DATA:       tx_push  = 1'b1;
            default: tx_push = 1'b0;
         endcase
      end

      // Serial engine, SPI mode 0, MSB first
      if (q.st != ssi_pkg::ST_IDLE)
         d.div = tick ? 16'h0000 : q.div + 16'h0001;
      unique case (q.st)
         ssi_pkg::ST_IDLE:
         begin
            d.div = 16'h0000;
            if (q.en && (q.tx_cnt != '0) && (half != 16'h0000))
            begin
               tx_pop     = 1'b1;
               d.cs_act   = 1'b1;
               d.bits     = 6'h00;
               d.frames   = 16'h0000;
               d.rx_phase = mode == ssi_pkg::MODE_RX;
               // Receive-only pops one dummy word and keeps the line still
               d.tx_sr    = (mode == ssi_pkg::MODE_RX) ? 32'h0 : pop_word;
               d.mosi     = (mode == ssi_pkg::MODE_RX) ? ssi_pkg::MOSI_IDLE : pop_word[q.dfs];
               d.st       = ssi_pkg::ST_LEAD;
            end
         end
         ssi_pkg::ST_LEAD:
         begin
            if (tick)
            begin
               d.sclk  = 1'b1;
               d.rx_sr = {q.rx_sr[30:0], q.miso_filt};
               d.bits  = q.bits + 6'h01;
               d.st    = ssi_pkg::ST_TRAIL;
            end
         end
         ssi_pkg::ST_TRAIL:
         begin
            if (tick)
            begin
               d.sclk = 1'b0;
               d.st   = ssi_pkg::ST_LEAD;
               if (q.bits == ({1'b0, q.dfs} + 6'h01))
               begin
                  d.bits = 6'h00;
                  // Transmit-only drops the frame; EEPROM read stores only after the
                  // command phase
                  rx_push = (mode == ssi_pkg::MODE_TXRX) || (mode == ssi_pkg::MODE_RX) ||
                            ((mode == ssi_pkg::MODE_EEPROM) && q.rx_phase);
                  if (q.rx_phase)
                  begin
                     d.frames = q.frames + 16'h0001;
                     d.mosi   = ssi_pkg::MOSI_IDLE;
                     if (q.frames == q.frame_count_minus_one)
                     begin
                        d.st     = ssi_pkg::ST_IDLE;
                        d.cs_act = 1'b0;
                     end
                  end
                  else if (q.tx_cnt != '0)
                  begin
                     tx_pop  = 1'b1;
                     d.tx_sr = pop_word;
                     d.mosi  = pop_word[q.dfs];
                  end
                  else if (mode == ssi_pkg::MODE_EEPROM)
                  begin
                     // Only a master reaches this mode; this block has no slave side
                     d.rx_phase = 1'b1;
                     d.frames   = 16'h0000;
                     d.mosi     = ssi_pkg::MOSI_IDLE;
                  end
                  else
                  begin
                     d.st     = ssi_pkg::ST_IDLE;
                     d.cs_act = 1'b0;
                     d.mosi   = ssi_pkg::MOSI_IDLE;
                  end
               end
               else
               begin
                  d.tx_sr = shifted;
                  d.mosi  = q.rx_phase ? ssi_pkg::MOSI_IDLE : shifted[q.dfs];
               end
            end
         end
         default: d.st = ssi_pkg::ST_IDLE;
      endcase

      // FIFO updates; event flags are set last so a set beats a clear
      if (tx_push)
      begin
         if (q.tx_cnt == FULL)
            d.txo = 1'b1;
         else
         begin
            d.tx_mem[q.tx_wr] = hwdata;
            d.tx_wr = q.tx_wr + AW'(1);
         end
      end
      if (tx_pop)
         d.tx_rd = q.tx_rd + AW'(1);
      d.tx_cnt = q.tx_cnt + (AW + 1)'(tx_push && (q.tx_cnt != FULL)) - (AW + 1)'(tx_pop);

      if (rx_push)
      begin
         if (q.rx_cnt == FULL)
            d.rxo = 1'b1;
         else
         begin
            d.rx_mem[q.rx_wr] = rx_word;
            d.rx_wr = q.rx_wr + AW'(1);
         end
      end
      if (rx_pop)
         d.rx_rd = q.rx_rd + AW'(1);
      d.rx_cnt = q.rx_cnt + (AW + 1)'(rx_push && (q.rx_cnt != FULL)) - (AW + 1)'(rx_pop);

      if (q.en && q.sel_filt)
         d.mst = 1'b1;

      // Disabling drops any frame in flight and empties both FIFOs
      if (!d.en)
      begin
         d.tx_rd    = '0;
         d.tx_wr    = '0;
         d.tx_cnt   = '0;
         d.rx_rd    = '0;
         d.rx_wr    = '0;
         d.rx_cnt   = '0;
         d.st       = ssi_pkg::ST_IDLE;
         d.cs_act   = 1'b0;
         d.sclk     = 1'b0;
         d.mosi     = ssi_pkg::MOSI_IDLE;
         d.rx_phase = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q <= '0;
      else
         q <= d;
   end

endmodule

`default_nettype wire

// file: tb/ssi_fifo_ctrl_properties.sv
// Checker for ssi_fifo_ctrl: flag clears, sticky flags, combined request, serial idle.
// Assumes single AHB-Lite transfers, never back to back.
`timescale 1ns/10ps
`default_nettype none
module ssi_fifo_ctrl_properties (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire ssi_pkg::spi_out_t spi_out,
   input wire ssi_pkg::irq_t     irq,
   input wire logic              irq_combined
);
   logic       wr_q;
   logic [7:0] wa_q;
   logic       rd_now;
   logic [7:0] adr;
   assign adr = haddr[7:0];
   assign rd_now = hsel && htrans[1] && hready && !hwrite;
   // ----------------------------------------
   // Write data phase tracking
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end
      else
      begin
         wr_q <= hsel && htrans[1] && hready && hwrite;
         wa_q <= adr;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A pending write may change the mask, so it is kept out of the cause
   sequence s_empty_read;
      rd_now && adr == ssi_pkg::OFF_DATA && !irq.rxu && !wr_q ##1 irq.rxu;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_irq_or_all: assert property (irq_combined == |irq)
      else $error("combined request differs from OR of sources");
   a_txo_clear_read: assert property (
      rd_now && adr == ssi_pkg::OFF_TXO_CLR && !(wr_q && wa_q == ssi_pkg::OFF_DATA) |=> !irq.txo)
      else $error("tx overflow flag not cleared by its read");
   a_rxu_clear_read: assert property (rd_now && adr == ssi_pkg::OFF_RXU_CLR |=> !irq.rxu)
      else $error("rx underflow flag not cleared by its read");
   a_rxo_clear_read: assert property (
      rd_now && adr == ssi_pkg::OFF_RXO_CLR && spi_out.cs_n |=> !irq.rxo)
      else $error("rx overflow flag not cleared by its read");
   a_txo_stays_set: assert property (
      irq.txo && !wr_q && !(rd_now && adr == ssi_pkg::OFF_TXO_CLR) |=> irq.txo)
      else $error("tx overflow flag dropped without a clear");
   a_empty_read_zero: assert property (s_empty_read |-> hrdata == 32'h0)
      else $error("read of empty rx fifo returned nonzero data");
   a_mosi_held_high: assert property (spi_out.sclk && $past(spi_out.sclk) |-> $stable(spi_out.mosi))
      else $error("serial out changed while serial clock high");
   a_sclk_idle_low: assert property (spi_out.cs_n |-> !spi_out.sclk)
      else $error("serial clock active outside a transfer");
endmodule
bind ssi_fifo_ctrl ssi_fifo_ctrl_properties u_ssi_fifo_ctrl_properties (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .spi_out(spi_out), .irq(irq), .irq_combined(irq_combined));
`default_nettype wire

// file: tb/spi_slave_model.sv
// Serial slave model: mode 0, MSB first, 8-bit frames, fixed reply byte.
// Assumes chip select stays low for a whole transfer and the clock idles low.
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
   input  wire ssi_pkg::spi_out_t spi_out,
   input  wire logic [7:0]        reply,
   input  wire logic              other_sel_n,
   output wire ssi_pkg::spi_in_t  spi_in
);
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic       miso_r = 1'b0;
   int         nb = 0;
   logic [7:0] got[$];
   // ----------------------------------------
   // Shifting
   // ----------------------------------------
   always @(negedge spi_out.cs_n)
   begin
      nb = 0;
      tx_sh = reply;
      miso_r = reply[7];
   end
   always @(posedge spi_out.sclk)
   begin
      rx_sh = {rx_sh[6:0], spi_out.mosi};
      nb = (nb == 7) ? 0 : nb + 1;
      if (nb == 0)
         got.push_back(rx_sh);
   end
   // Released line shows the inverse of its last bit, so stale data never passes
   always @(negedge spi_out.sclk or posedge spi_out.cs_n)
   begin
      tx_sh = (nb == 0) ? reply : {tx_sh[6:0], 1'b0};
      miso_r = spi_out.cs_n ? ~miso_r : tx_sh[7];
   end
   assign spi_in = '{ss_in_n: other_sel_n, miso: miso_r};
endmodule
`default_nettype wire

// file: tb/ssi_fifo_ctrl_test.sv
// Self-checking bench for ssi_fifo_ctrl: AHB-Lite register tasks plus a serial slave.
// Assumes 8-bit frames and a slave that always answers with the reply byte.
`timescale 1ns/10ps
`default_nettype none
module ssi_fifo_ctrl_test;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [31:0]       hwdata = 32'h0;
   logic              other_sel_n = 1'b1;
   logic [7:0]        reply = 8'hc3;
   wire               hreadyout;
   wire               hresp;
   wire [31:0]        hrdata;
   wire               irq_combined;
   wire               hready;
   wire ssi_pkg::spi_in_t  spi_in;
   wire ssi_pkg::spi_out_t spi_out;
   wire ssi_pkg::irq_t     irq;
   int                err_count = 0;
   int                checks_done = 0;
   always #25 hclk = ~hclk;
   assign hready = hreadyout;
   ssi_fifo_ctrl u_ssi_fifo_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .spi_in(spi_in), .spi_out(spi_out), .irq(irq), .irq_combined(irq_combined));
   spi_slave_model u_spi_slave_model (.spi_out(spi_out), .reply(reply), .other_sel_n(other_sel_n), .spi_in(spi_in));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic ck_irq(input logic [5:0] e);
      @(negedge hclk);
      chk({26'h0, irq}, {26'h0, e});
   endtask
   // Polls status until the tx fifo is empty and the engine is idle
   task automatic idle;
      logic [31:0] s;
      int n;
      n = 0;
      s = 32'h0;
      while (!(s[2] && !s[0]) && n < 600)
      begin
         bus(ssi_pkg::OFF_STATUS, 1'b0, 32'h0, s);
         n++;
      end
   endtask
   task automatic frames(input int g, input int n, input int f, input logic [1:0] m);
      chk(32'(u_spi_slave_model.got.size() - g), 32'(f));
      for (int k = 0; k < f; k++)
         chk({24'h0, u_spi_slave_model.got[g + k]},
             (m != ssi_pkg::MODE_RX && k < n) ? 32'h40 + 32'(k) : {24'h0, {8{ssi_pkg::MOSI_IDLE}}});
   endtask
   // Bits 3:0 carry ones on purpose: they must not change the frame size
   task automatic xfer(input logic [3:0] m, input int frame_count_minus_one, input int n, input int nrx);
      int g;
      g = u_spi_slave_model.got.size();
      wr(ssi_pkg::OFF_CTRL0, (32'd7 << ssi_pkg::CTRL0_DFS_LSB) | (32'(m[1:0]) << ssi_pkg::CTRL0_TRANSFER_MODE_FIELD_LSB) |
         (32'(m[3:2]) << ssi_pkg::CTRL0_FRF_LSB) | 32'hf);
      wr(ssi_pkg::OFF_CTRL1, 32'(frame_count_minus_one));
      for (int i = 0; i < n; i++)
         wr(ssi_pkg::OFF_DATA, 32'hdead_be40 + 32'(i));
      idle();
      frames(g, n, (m == ssi_pkg::MODE_RX) ? frame_count_minus_one + 1 : (m == ssi_pkg::MODE_EEPROM) ? n + frame_count_minus_one + 1 : n, m[1:0]);
      rc(ssi_pkg::OFF_RX_LEVEL, 32'(nrx));
      repeat (nrx) rc(ssi_pkg::OFF_DATA, {24'h0, reply});
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      logic [31:0] r;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rc(ssi_pkg::OFF_IRQ_RAW, 32'h1);
      ck_irq(6'h00);
      wr(ssi_pkg::OFF_MASK, 32'h3f);
      ck_irq(6'h01);
      chk({31'h0, irq_combined}, 32'h1);
      wr(ssi_pkg::OFF_TX_THRESH, 32'h2);
      wr(ssi_pkg::OFF_RX_THRESH, 32'hf);
      xfer(ssi_pkg::MODE_TXRX, 0, 0, 0);
      wr(ssi_pkg::OFF_ENABLE, 32'h1);
      for (int i = 0; i < 17; i++)
      begin
         wr(ssi_pkg::OFF_DATA, 32'hdead_be40 + 32'(i));
         if (i == 1 || i == 2)
            ck_irq({5'h0, i == 1});
      end
      rc(ssi_pkg::OFF_TX_LEVEL, 32'd16);
      ck_irq(6'h02);
      bus(ssi_pkg::OFF_TXO_CLR, 1'b0, 32'h0, r);
      ck_irq(6'h00);
      $display("tx fifo test done");
      wr(ssi_pkg::OFF_BAUD, 32'ha);
      idle();
      frames(0, 16, 16, ssi_pkg::MODE_TXRX);
      rc(ssi_pkg::OFF_RX_LEVEL, 32'd16);
      ck_irq(6'h11);
      wr(ssi_pkg::OFF_DATA, 32'hdead_be40);
      idle();
      frames(16, 1, 1, ssi_pkg::MODE_TXRX);
      ck_irq(6'h19);
      rc(ssi_pkg::OFF_RX_LEVEL, 32'd16);
      rc(ssi_pkg::OFF_DATA, {24'h0, reply});
      ck_irq(6'h09);
      repeat (15) rc(ssi_pkg::OFF_DATA, {24'h0, reply});
      rc(ssi_pkg::OFF_DATA, 32'h0);
      ck_irq(6'h0d);
      bus(ssi_pkg::OFF_RXO_CLR, 1'b0, 32'h0, r);
      bus(ssi_pkg::OFF_RXU_CLR, 1'b0, 32'h0, r);
      ck_irq(6'h01);
      $display("rx fifo test done");
      wr(ssi_pkg::OFF_MASK, 32'h23);
      xfer(ssi_pkg::MODE_TX, 0, 2, 0);
      wr(ssi_pkg::OFF_MASK, 32'h3c);
      xfer(ssi_pkg::MODE_RX, 2, 1, 3);
      xfer(ssi_pkg::MODE_EEPROM, 1, 2, 2);
      wr(ssi_pkg::OFF_THREE_WIRE, 32'h1);
      xfer({ssi_pkg::FRF_THREE_WIRE, ssi_pkg::MODE_TXRX}, 0, 1, 0);
      $display("transfer mode test done");
      wr(ssi_pkg::OFF_BAUD, 32'h0);
      wr(ssi_pkg::OFF_DATA, 32'h1);
      wr(ssi_pkg::OFF_ENABLE, 32'h0);
      wr(ssi_pkg::OFF_ENABLE, 32'h1);
      rc(ssi_pkg::OFF_TX_LEVEL, 32'h0);
      $display("disable test done");
      wr(ssi_pkg::OFF_MASK, 32'h3f);
      other_sel_n <= 1'b0;
      repeat (10) @(posedge hclk);
      other_sel_n <= 1'b1;
      repeat (10) @(posedge hclk);
      ck_irq(6'h21);
      rc(ssi_pkg::OFF_MST_CLR, 32'h1);
      ck_irq(6'h01);
      rc(8'h50, 32'h0);
      wr(ssi_pkg::OFF_MASK, 32'h0);
      ck_irq(6'h00);
      chk({31'h0, irq_combined}, 32'h0);
      $display("contention and mask test done");
      stop_test();
   end
   initial
   begin
      #1000000;
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
